//--- design/btm_monitor.sv
// Bus time-out monitor: configuration, time-out control and fault flag registers
//
// Summary of operation
// - Config bit 5 shows instruction cache health
// - Idle peripheral unacknowledged 512 cycles gives error
// - Peripheral expiry enable bit 0, resets 1
// - External memory expiry enable bit 1, resets 0
// - CPU time-out becomes CPU bus fault
// - DMA time-out sets DMA status flag
// - Control bits 15 to 2 read zero
// - Peripheral time-out sets peripheral fault bit 12
// - External data access time-out sets bit 12
// - Fetch time-out sets fetch fault bit 12
`include "btm_regs.svh"

module btm_monitor
  import btm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instrCacheOk,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic periphReq,
  input wire logic periphIdle,
  input wire logic periphIsDma,
  input wire logic periphAck,
  input wire logic extReq,
  input wire btm_src_t extSrc,
  input wire logic extAck,
  input wire logic fetchReq,
  input wire logic fetchAck,
  output logic periphExpiry,
  output logic extmemExpiry,
  output logic fetchExpiry,
  output logic cpuBusFault,
  output logic dmaExpiry
);

  // ----------------------------------------
  // Stall timers
  // ----------------------------------------
  btm_state_t q;
  btm_state_t d;
  logic periphTmo;
  logic extTmo;
  logic fetchTmo;
  logic periphActive;

  // Only a disabled or idled target can leave an access hanging
  assign periphActive = periphReq && periphIdle;

  btm_timer u_periph_timer (
    .clk(clk),
    .rst(rst),
    .active(periphActive),
    .ack(periphAck),
    .enable(q.periphEn),
    .expired(periphTmo)
  );

  btm_timer u_ext_timer (
    .clk(clk),
    .rst(rst),
    .active(extReq),
    .ack(extAck),
    .enable(q.extmemEn),
    .expired(extTmo)
  );

  btm_timer u_fetch_timer (
    .clk(clk),
    .rst(rst),
    .active(fetchReq),
    .ack(fetchAck),
    .enable(q.extmemEn),
    .expired(fetchTmo)
  );

  // ----------------------------------------
  // Register access and error routing
  // ----------------------------------------
  logic extFromCpu;
  logic extFromDma;
  logic rdPer;
  logic rdDat;
  logic rdFet;

  assign extFromCpu = extSrc == BTM_SRC_CPU;
  assign extFromDma = extSrc == BTM_SRC_DMA;
  assign rdPer = regRd && regAddr == `BTM_PERFLT_ADDR;
  assign rdDat = regRd && regAddr == `BTM_DATFLT_ADDR;
  assign rdFet = regRd && regAddr == `BTM_FETFLT_ADDR;

  // Next state; read data is registered so reads answer one cycle later
  always_comb begin
    d = q;
    d.cacheOk = instrCacheOk;
    // Writes touch only the writable bits; everything else is fixed
    if (regWr && regAddr == `BTM_SYSCFG_ADDR) begin
      d.cfgRsvd = regWdata[`BTM_CFG_RSVW_BIT];
    end
    if (regWr && regAddr == `BTM_TOCTRL_ADDR) begin
      d.periphEn = regWdata[`BTM_PERIPH_EN_BIT];
      d.extmemEn = regWdata[`BTM_EXTMEM_EN_BIT];
    end
    // Fault flags clear on read, but a fresh event in the same cycle wins
    if (rdPer) begin
      d.periphFlag = 1'b0;
    end
    if (rdDat) begin
      d.dataFlag = 1'b0;
    end
    if (rdFet) begin
      d.fetchFlag = 1'b0;
    end
    if (periphTmo) begin
      d.periphFlag = 1'b1;
    end
    if (extTmo) begin
      d.dataFlag = 1'b1;
    end
    if (fetchTmo) begin
      d.fetchFlag = 1'b1;
    end
    // Read mux; unmapped addresses read zero
    d.rdata = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        `BTM_SYSCFG_ADDR: begin
          d.rdata = {`BTM_CFG_HIGH_RST, q.cacheOk, q.cfgRsvd, 4'h0};
        end
        `BTM_TOCTRL_ADDR: begin
          d.rdata = {14'h0000, q.extmemEn, q.periphEn};
        end
        `BTM_PERFLT_ADDR: begin
          d.rdata = {3'h0, q.periphFlag, 12'h000};
        end
        `BTM_DATFLT_ADDR: begin
          d.rdata = {3'h0, q.dataFlag, 12'h000};
        end
        `BTM_FETFLT_ADDR: begin
          d.rdata = {3'h0, q.fetchFlag, 12'h000};
        end
        default: begin
          d.rdata = 16'h0000;
        end
      endcase
    end
    // Error pulses back to the requesters
    d.periphExpiry = periphTmo;
    d.extmemExpiry = extTmo;
    d.fetchExpiry = fetchTmo;
    // A fetch stall also faults the CPU since it waits on the fetch
    d.cpuBusFault = (periphTmo && !periphIsDma) || (extTmo && extFromCpu) || fetchTmo;
    d.dmaExpiry = (periphTmo && periphIsDma) || (extTmo && extFromDma);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.periphEn <= `BTM_PERIPH_EN_RST;
      q.extmemEn <= `BTM_EXTMEM_EN_RST;
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.rdata;
  assign periphExpiry = q.periphExpiry;
  assign extmemExpiry = q.extmemExpiry;
  assign fetchExpiry = q.fetchExpiry;
  assign cpuBusFault = q.cpuBusFault;
  assign dmaExpiry = q.dmaExpiry;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_cfgFixedBits;
    @(posedge clk) disable iff (rst) regRd && regAddr == `BTM_SYSCFG_ADDR |=>
      regRdata[15:6] == 10'h208 && regRdata[3:0] == 4'h0;
  endproperty
  a_cfgFixedBits: assert property (p_cfgFixedBits) else $error("Config fixed bits wrong");

  property p_cacheStatus;
    @(posedge clk) disable iff (rst) regRd && regAddr == `BTM_SYSCFG_ADDR |=>
      regRdata[5] == $past(q.cacheOk);
  endproperty
  a_cacheStatus: assert property (p_cacheStatus) else $error("Cache status bit wrong");

  property p_ctrlUpper;
    @(posedge clk) disable iff (rst) regRd && regAddr == `BTM_TOCTRL_ADDR |=> regRdata[15:2] == 14'h0000;
  endproperty
  a_ctrlUpper: assert property (p_ctrlUpper) else $error("Control upper bits nonzero");

  property p_ctrlReset;
    @(posedge clk) rst |=> q.periphEn && !q.extmemEn;
  endproperty
  a_ctrlReset: assert property (p_ctrlReset) else $error("Control reset value wrong");

  property p_ctrlWrite;
    @(posedge clk) disable iff (rst) regWr && regAddr == `BTM_TOCTRL_ADDR |=>
      q.periphEn == $past(regWdata[0]) && q.extmemEn == $past(regWdata[1]);
  endproperty
  a_ctrlWrite: assert property (p_ctrlWrite) else $error("Control write lost");

  property p_periphFlag;
    @(posedge clk) disable iff (rst) periphTmo |=> q.periphFlag && periphExpiry;
  endproperty
  a_periphFlag: assert property (p_periphFlag) else $error("Peripheral fault flag not set");

  property p_dataFlag;
    @(posedge clk) disable iff (rst) extTmo |=> q.dataFlag ##0 extmemExpiry;
  endproperty
  a_dataFlag: assert property (p_dataFlag) else $error("Data port fault flag not set");

  property p_fetchFlag;
    @(posedge clk) disable iff (rst) fetchTmo |=> q.fetchFlag && cpuBusFault;
  endproperty
  a_fetchFlag: assert property (p_fetchFlag) else $error("Fetch fault flag not set");

  property p_cpuFault;
    @(posedge clk) disable iff (rst) periphTmo && !periphIsDma && !(extTmo && extFromDma) |=>
      cpuBusFault && !dmaExpiry;
  endproperty
  a_cpuFault: assert property (p_cpuFault) else $error("CPU bus fault missing");

  property p_dmaFault;
    @(posedge clk) disable iff (rst) (periphTmo && periphIsDma) || (extTmo && extFromDma) |=> dmaExpiry;
  endproperty
  a_dmaFault: assert property (p_dmaFault) else $error("DMA expiry missing");

  property p_extDisabled;
    @(posedge clk) disable iff (rst) !q.extmemEn [*2] |=> !extmemExpiry && !fetchExpiry;
  endproperty
  a_extDisabled: assert property (p_extDisabled) else $error("External expiry while disabled");

endmodule : btm_monitor

//--- inc/btm_regs.svh
// Register offsets, field positions, reset values and timing counts of the time-out monitor
`ifndef BTM_REGS_SVH
`define BTM_REGS_SVH

// ----------------------------------------
// Word addresses
// ----------------------------------------
`define BTM_SYSCFG_ADDR 16'h07fd
`define BTM_TOCTRL_ADDR 16'h9000
`define BTM_PERFLT_ADDR 16'h0102
`define BTM_DATFLT_ADDR 16'h0202
`define BTM_FETFLT_ADDR 16'h0302

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BTM_CACHE_OK_BIT 5
`define BTM_CFG_RSVW_BIT 4
`define BTM_PERIPH_EN_BIT 0
`define BTM_EXTMEM_EN_BIT 1
`define BTM_EXPIRY_BIT 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BTM_CFG_HIGH_RST 10'h208
`define BTM_PERIPH_EN_RST 1'b1
`define BTM_EXTMEM_EN_RST 1'b0

// ----------------------------------------
// Timing: stall limit in CPU clock cycles
// ----------------------------------------
`define BTM_STALL_CYCLES 512
`define BTM_CNT_W 10

`endif

//--- inc/btm_pkg.sv
// Types shared by the time-out monitor modules
package btm_pkg;

  // ----------------------------------------
  // Requester of an external memory access
  // ----------------------------------------
  typedef enum logic [1:0] {
    BTM_SRC_CPU,
    BTM_SRC_DMA,
    BTM_SRC_HOST,
    BTM_SRC_FETCH
  } btm_src_t;

  // ----------------------------------------
  // Stall timer state
  // ----------------------------------------
  typedef struct packed {
    logic [9:0] count;
    logic done;
    logic expired;
  } btm_tmr_t;

  // ----------------------------------------
  // Monitor state
  // ----------------------------------------
  typedef struct packed {
    logic cfgRsvd;
    logic cacheOk;
    logic periphEn;
    logic extmemEn;
    logic periphFlag;
    logic dataFlag;
    logic fetchFlag;
    logic [15:0] rdata;
    logic cpuBusFault;
    logic dmaExpiry;
    logic periphExpiry;
    logic extmemExpiry;
    logic fetchExpiry;
  } btm_state_t;

endpackage : btm_pkg

//--- design/btm_timer.sv
// Stall timer: counts cycles of one unacknowledged access and flags expiry
`include "btm_regs.svh"

module btm_timer
  import btm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic active,
  input wire logic ack,
  input wire logic enable,
  output logic expired
);

  localparam logic [9:0] LastCount = 10'(`BTM_STALL_CYCLES - 1);

  btm_tmr_t q;
  btm_tmr_t d;

  // Count while the access waits; fire once per access
  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (!active || ack) begin
      d.count = 10'h000;
      d.done = 1'b0;
    end else if (!q.done) begin
      if (q.count == LastCount) begin
        d.done = 1'b1;
        d.expired = enable;
      end else begin
        d.count = q.count + 10'h001;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_expiryAtLimit;
    @(posedge clk) disable iff (rst) expired |-> $past(q.count) == LastCount && $past(active) && !$past(ack);
  endproperty
  a_expiryAtLimit: assert property (p_expiryAtLimit) else $error("Expiry not at stall limit");

  property p_clearOnAck;
    @(posedge clk) disable iff (rst) (ack || !active) |=> q.count == 10'h000 && !expired;
  endproperty
  a_clearOnAck: assert property (p_clearOnAck) else $error("Stall count not cleared");

  property p_noExpiryDisabled;
    @(posedge clk) disable iff (rst) !enable |=> !expired;
  endproperty
  a_noExpiryDisabled: assert property (p_noExpiryDisabled) else $error("Expiry while disabled");

endmodule : btm_timer

//--- verif/btm_access_model.sv
// Requester and target pair that holds one access pending and answers it after a set delay
module btm_access_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [10:0] ackAfter,
  output logic req,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [10:0] cnt_q;

  // ----------------------------------------
  // Access sequencing
  // ----------------------------------------
  // Request stands until the acknowledge edge; a silent target is abandoned so each access ends
  always_ff @(posedge clk) begin
    ack <= 1'b0;
    if (rst) begin
      req <= 1'b0;
      cnt_q <= 11'h000;
    end else if (start) begin
      req <= 1'b1;
      cnt_q <= 11'h000;
    end else if (req) begin
      cnt_q <= cnt_q + 11'h001;
      if (ack || cnt_q == 11'h2bc) begin
        req <= 1'b0; // Dropped after the acknowledge or the give-up count
      end else if (cnt_q == ackAfter) begin
        ack <= 1'b1;
      end
    end
  end
endmodule : btm_access_model

//--- verif/tb_top.sv
// Self-checking bench for the bus time-out monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, instrCacheOk, regWr, regRd, periphIdle, periphIsDma, start, req, ack;
  logic [15:0] regAddr, regWdata, regRdata;
  logic [10:0] ackAfter;
  logic [1:0] sel;
  logic periphExpiry, extmemExpiry, fetchExpiry, cpuBusFault, dmaExpiry;
  btm_pkg::btm_src_t extSrc;
  int error_cnt = 0;
  int comparisons = 0;
  logic [4:0] seen;
  int at;

  btm_monitor dut (.clk(clk), .rst(rst), .instrCacheOk(instrCacheOk), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .periphReq(req && sel == 2'h0), .periphIdle(periphIdle), .periphIsDma(periphIsDma),
    .periphAck(ack && sel == 2'h0), .extReq(req && sel == 2'h1), .extSrc(extSrc),
    .extAck(ack && sel == 2'h1), .fetchReq(req && sel == 2'h2), .fetchAck(ack && sel == 2'h2),
    .periphExpiry(periphExpiry), .extmemExpiry(extmemExpiry), .fetchExpiry(fetchExpiry),
    .cpuBusFault(cpuBusFault), .dmaExpiry(dmaExpiry));

  btm_access_model peer (.clk(clk), .rst(rst), .start(start), .ackAfter(ackAfter), .req(req), .ack(ack));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge clk);
    regWr = 1'b0;
  endtask : wr

  // Read data is looked at in the one cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk);
    regRd = 1'b0;
    check(regRdata, exp);
  endtask : rd

  // Error outputs {periph, extmem, fetch, cpu, dma} gathered over one access, with first pulse cycle
  task automatic access(input logic [1:0] s, input logic [10:0] aa);
    logic [4:0] v;
    sel = s;
    ackAfter = aa;
    start = 1'b1;
    seen = 5'h00;
    at = 0;
    @(negedge clk);
    start = 1'b0;
    for (int n = 1; n <= 720; n++) begin
      v = {periphExpiry, extmemExpiry, fetchExpiry, cpuBusFault, dmaExpiry};
      if (v !== 5'h00 && at == 0) at = n;
      seen = seen | v;
      @(negedge clk);
    end
  endtask : access

  task automatic conclude;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs;
    // Cache health lands in the config register one edge after reset lets go
    @(negedge clk);
    rd(16'h07fd, 16'h8220);
    rd(16'h9000, 16'h0001);
    wr(16'h9000, 16'hffff);
    rd(16'h9000, 16'h0003);
    wr(16'h07fd, 16'hffef);
    rd(16'h07fd, 16'h8220);
    instrCacheOk = 1'b0;
    @(negedge clk);
    rd(16'h07fd, 16'h8200);
    rd(16'h1234, 16'h0000);
    wr(16'h9000, 16'h0001);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_periph;
    periphIdle = 1'b1;
    access(2'h0, 11'h7ff);
    check(16'(seen), 16'h0012);
    check(16'(at), 16'h0202);
    rd(16'h0102, 16'h1000);
    rd(16'h0102, 16'h0000);
    periphIsDma = 1'b1;
    access(2'h0, 11'h1f4);
    check(16'(seen), 16'h0000);
    access(2'h0, 11'h7ff);
    check(16'(seen), 16'h0011);
    check(16'(at), 16'h0202);
    wr(16'h9000, 16'h0000);
    access(2'h0, 11'h7ff);
    check(16'(seen), 16'h0000);
    wr(16'h9000, 16'h0001);
    periphIdle = 1'b0;
    access(2'h0, 11'h7ff);
    check(16'(seen), 16'h0000);
    $display("test_periph done");
  endtask : test_periph

  // Every requester source in turn; CPU and DMA each route their error, host and fetch raise only extmem expiry
  task automatic test_ext;
    logic [4:0] exp [4] = '{5'h0a, 5'h09, 5'h08, 5'h08};
    access(2'h1, 11'h7ff);
    check(16'(seen), 16'h0000);
    wr(16'h9000, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      extSrc = btm_pkg::btm_src_t'(i);
      access(2'h1, 11'h7ff);
      check(16'(seen), 16'(exp[i]));
      check(16'(at), 16'h0202);
      rd(16'h0202, 16'h1000);
    end
    access(2'h2, 11'h7ff);
    check(16'(seen), 16'h0006);
    rd(16'h0302, 16'h1000);
    wr(16'h9000, 16'h0001);
    $display("test_ext done");
  endtask : test_ext

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Roughly eleven accesses of 720 cycles each; nearly five times that is ample
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    instrCacheOk = 1'b1;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    periphIdle = 1'b0;
    periphIsDma = 1'b0;
    extSrc = btm_pkg::BTM_SRC_CPU;
    sel = 2'h3;
    start = 1'b0;
    ackAfter = 11'h7ff;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    test_regs();
    test_periph();
    test_ext();
    conclude();
  end
endmodule : tb_top
